// *** design/rsi_reset_state_init.sv ***
// Reset-state register bank: ports, capture/compare and serial registers
// initialised by reset class, with the wake-up vector and stack handling.
// Assumes an APB master on ref_clk; reset-class strobes are one-cycle pulses
// from logic on ref_clk; port pins are asynchronous.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module rsi_reset_state_init import rsi_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rsi_event_t resetEvent,
  input wire logic oscFreesPins,
  input wire logic [20:0] corePc,
  input wire logic [7:0] wakeCause,
  input wire logic [8:0][7:0] portPins,
  output logic [8:0][7:0] portDirection,
  output logic [8:0][7:0] portLatch,
  output logic [12:0][7:0] periphRegs,
  output rsi_class_t resetClass,
  output logic pcLoad,
  output logic [20:0] pcValue,
  output logic [4:0] stackPointer,
  output logic [7:0] irqFlags,
  output logic [1:0] globalIrqEnable
);
  logic [8:0][7:0] pinRead;
  logic [20:0] stackTop;
  logic [31:0] next_prdata;
  wire logic [12:0][7:0] next_periph;

  // Class decode: power-on outranks other resets, which outrank wake-up
  wire logic isPor = resetEvent.por;
  wire logic isSys = !resetEvent.por && resetEvent.sys;
  wire logic isWake = !resetEvent.por && !resetEvent.sys && resetEvent.wake;
  wire logic anyReset = isPor || isSys;
  wire rsi_class_t next_class = isPor ? RSI_CLS_POR :
                                isSys ? RSI_CLS_SYS :
                                isWake ? RSI_CLS_WAKE : RSI_CLS_NONE;

  // Port A upper pair follows the oscillator mode
  wire logic [7:0] portAEnable = oscFreesPins ? 8'hff : ~RSI_OSC_BITS;

  // Bus decode
  wire logic access = psel && penable && pready;
  wire logic wrEn = access && pwrite && pstrb[0];
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic [11:0] relDir = paddr - RSI_OFF_DIR;
  wire logic [11:0] relLat = paddr - RSI_OFF_LAT;
  wire logic [11:0] relPin = paddr - RSI_OFF_PIN;
  wire logic [11:0] relMisc = paddr - RSI_OFF_MISC;
  wire logic aligned = paddr[1:0] == 2'b00;
  wire logic hitDir = aligned && paddr >= RSI_OFF_DIR && relDir[11:2] < 10'(RSI_PORTS);
  wire logic hitLat = aligned && paddr >= RSI_OFF_LAT && relLat[11:2] < 10'(RSI_PORTS);
  wire logic hitPin = aligned && paddr >= RSI_OFF_PIN && relPin[11:2] < 10'(RSI_PORTS);
  wire logic hitMisc = aligned && paddr >= RSI_OFF_MISC && relMisc[11:2] < 10'(RSI_MISC);
  wire logic hitPc = paddr == RSI_OFF_PC;
  wire logic hitSp = paddr == RSI_OFF_SP;
  wire logic hitTop = paddr == RSI_OFF_STKTOP;
  wire logic hitFlags = paddr == RSI_OFF_FLAGS;
  wire logic hitGie = paddr == RSI_OFF_GIE;
  wire logic mapped = hitDir || hitLat || hitPin || hitMisc || hitPc || hitSp ||
                      hitTop || hitFlags || hitGie;
  wire logic [3:0] dirIdx = relDir[5:2];
  wire logic [3:0] latIdx = relLat[5:2];
  wire logic [3:0] pinIdx = relPin[5:2];
  wire logic [3:0] miscIdx = relMisc[5:2];
  wire logic [7:0] flagClr = (wrEn && hitFlags) ? wbyte : 8'h00;

  genvar g;
  generate
    for (g = 0; g < RSI_PORTS; g++) begin : gPort
      rsi_port_reg #(
        .DIR_MASK(RSI_DIR_MASK[g]),
        .DIR_RST(RSI_DIR_RST[g]),
        .LAT_MASK(RSI_LAT_MASK[g]),
        .LAT_CLR(RSI_LAT_CLR[g]),
        .PIN_MASK(RSI_PIN_MASK[g])
      ) uPort (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .anyReset(anyReset),
        .bitEnable(g == RSI_PORT_A ? portAEnable : 8'hff),
        .wrDir(wrEn && hitDir && dirIdx == 4'(g)),
        .wrLat(wrEn && hitLat && latIdx == 4'(g)),
        .wdata(wbyte),
        .pins(portPins[g]),
        .dir(portDirection[g]),
        .lat(portLatch[g]),
        .pinRead(pinRead[g])
      );
    end

    // Misc registers: reset loads only the bits with a defined value
    for (g = 0; g < RSI_MISC; g++) begin : gMisc
      wire logic hitThis = wrEn && hitMisc && miscIdx == 4'(g);
      wire logic [7:0] keptBits = periphRegs[g] & RSI_MISC_MASK[g] & ~RSI_MISC_LOAD[g];
      wire logic [7:0] resetVal = keptBits | RSI_MISC_RST[g];
      assign next_periph[g] = anyReset ? resetVal : hitThis ? wbyte & RSI_MISC_MASK[g] :
                              periphRegs[g];
    end
  endgenerate

  // One process for the whole bank keeps a single driver on the output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) periphRegs <= '0;
    else periphRegs <= next_periph;
  end

  rsi_wake_seq #(
    .DEPTH(RSI_STACK_DEPTH)
  ) uWake (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .anyReset(anyReset),
    .ev(resetEvent),
    .gie(globalIrqEnable),
    .corePc(corePc),
    .cause(wakeCause),
    .flagClr(flagClr),
    .pcLoad(pcLoad),
    .pcValue(pcValue),
    .stackPtr(stackPointer),
    .stackTop(stackTop),
    .irqFlags(irqFlags)
  );

  // Portless registers read the direction and latch of a masked-off port A bit as zero
  wire logic [7:0] dirRd = portDirection[dirIdx] & (dirIdx == 4'(RSI_PORT_A) ? portAEnable : 8'hff);
  wire logic [7:0] latRd = portLatch[latIdx] & (latIdx == 4'(RSI_PORT_A) ? portAEnable : 8'hff);

  always_comb begin
    next_prdata = 32'h00000000;
    if (hitDir) next_prdata = {24'h000000, dirRd};
    else if (hitLat) next_prdata = {24'h000000, latRd};
    else if (hitPin) next_prdata = {24'h000000, pinRead[pinIdx]};
    else if (hitMisc) next_prdata = {24'h000000, periphRegs[miscIdx]};
    else if (hitPc) next_prdata = {11'h000, pcValue};
    else if (hitSp) next_prdata = {27'h0000000, stackPointer};
    else if (hitTop) next_prdata = {11'h000, stackTop};
    else if (hitFlags) next_prdata = {24'h000000, irqFlags};
    else if (hitGie) next_prdata = {30'h00000000, globalIrqEnable};
  end

  // One wait state keeps every bus output a plain flip-flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalIrqEnable <= 2'b00;
      resetClass <= RSI_CLS_NONE;
    end else begin
      resetClass <= next_class;
      if (anyReset) globalIrqEnable <= 2'b00;
      else if (wrEn && hitGie) globalIrqEnable <= wbyte[1:0];
    end
  end

  property p_baudReset;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> periphRegs[0] == RSI_MISC_RST[0];
  endproperty
  a_baudReset: assert property (p_baudReset) else $error("baud control bad reset");

  property p_txStatus;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> periphRegs[11] == RSI_MISC_RST[11];
  endproperty
  a_txStatus: assert property (p_txStatus) else $error("tx status bad reset");

  property p_rxStatus;
    @(posedge ref_clk) disable iff (!rst_n)
      anyReset |=> periphRegs[12][7:1] == 7'h00 && periphRegs[12][0] == $past(periphRegs[12][0]);
  endproperty
  a_rxStatus: assert property (p_rxStatus) else $error("rx status bad reset");

  property p_ccpCtl;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> periphRegs[3] == 8'h00 && periphRegs[4] == 8'h00;
  endproperty
  a_ccpCtl: assert property (p_ccpCtl) else $error("compare control not cleared");

  property p_wakeKeeps;
    @(posedge ref_clk) disable iff (!rst_n) isWake && !wrEn |=> $stable(periphRegs) && $stable(portDirection);
  endproperty
  a_wakeKeeps: assert property (p_wakeKeeps) else $error("wake changed a register");

  property p_divClear;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> periphRegs[1] == 8'h00 ##0 periphRegs[2] == 8'h00
      ##0 periphRegs[9] == 8'h00 ##0 periphRegs[10] == 8'h00;
  endproperty
  a_divClear: assert property (p_divClear) else $error("divisor or data not cleared");

  property p_portGRead;
    @(posedge ref_clk) disable iff (!rst_n) pinRead[RSI_PORT_G][7:5] == 3'b000;
  endproperty
  a_portGRead: assert property (p_portGRead) else $error("port G high bits read one");

  property p_oscBits;
    @(posedge ref_clk) disable iff (!rst_n) !oscFreesPins |-> (pinRead[RSI_PORT_A] & RSI_OSC_BITS) == 8'h00;
  endproperty
  a_oscBits: assert property (p_oscBits) else $error("port A osc bits visible");

  property p_class;
    @(posedge ref_clk) disable iff (!rst_n) resetEvent.por |=> resetClass == RSI_CLS_POR;
  endproperty
  a_class: assert property (p_class) else $error("power-on not classed");

  property p_apbAnswer;
    @(posedge ref_clk) disable iff (!rst_n) psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer) else $error("bus answer timing");

  property p_portGDir;
    @(posedge ref_clk) disable iff (!rst_n)
      anyReset |=> portDirection[RSI_PORT_G] == RSI_DIR_RST[RSI_PORT_G];
  endproperty
  a_portGDir: assert property (p_portGDir) else $error("port G direction bad reset");

  // Undefined latch bits keep their content; only port G's top pair clears
  property p_latKeep;
    @(posedge ref_clk) disable iff (!rst_n)
      anyReset |=> portLatch == ($past(portLatch) & RSI_LAT_MASK & ~RSI_LAT_CLR);
  endproperty
  a_latKeep: assert property (p_latKeep) else $error("latch not kept on reset");

  property p_ccpValKeep;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> periphRegs[8:5] == $past(periphRegs[8:5]);
  endproperty
  a_ccpValKeep: assert property (p_ccpValKeep) else $error("compare value lost");

  property p_flagsHold;
    @(posedge ref_clk) disable iff (!rst_n)
      !isWake && !anyReset && !(wrEn && hitFlags) |=> $stable(irqFlags);
  endproperty
  a_flagsHold: assert property (p_flagsHold) else $error("flags moved without cause");

  // Without a global enable a wake must not vector or touch the stack
  property p_noVector;
    @(posedge ref_clk) disable iff (!rst_n)
      isWake && globalIrqEnable == 2'b00 |=> !pcLoad && $stable(stackPointer);
  endproperty
  a_noVector: assert property (p_noVector) else $error("vectored with enables clear");

  property p_resetVector;
    @(posedge ref_clk) disable iff (!rst_n)
      anyReset |=> pcLoad && pcValue == RSI_VEC_RESET && stackPointer == 5'h00;
  endproperty
  a_resetVector: assert property (p_resetVector) else $error("reset vector not loaded");

  property p_sysClass;
    @(posedge ref_clk) disable iff (!rst_n) isSys |=> resetClass == RSI_CLS_SYS;
  endproperty
  a_sysClass: assert property (p_sysClass) else $error("other reset not classed");

  property p_wakeClass;
    @(posedge ref_clk) disable iff (!rst_n) isWake |=> resetClass == RSI_CLS_WAKE;
  endproperty
  a_wakeClass: assert property (p_wakeClass) else $error("wake not classed");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!rst_n)
      psel && penable && !pready && !mapped |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");

  property p_upperZero;
    @(posedge ref_clk) disable iff (!rst_n) pready |-> prdata[31:21] == 11'h000;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper read bits set");

  property p_dirAMask;
    @(posedge ref_clk) disable iff (!rst_n)
      !oscFreesPins && hitDir && dirIdx == 4'(RSI_PORT_A) && psel && penable && !pready |=>
      (prdata[7:0] & RSI_OSC_BITS) == 8'h00;
  endproperty
  a_dirAMask: assert property (p_dirAMask) else $error("port A direction osc bits read");

  c_por: cover property (@(posedge ref_clk) disable iff (!rst_n) isPor);
  c_sys: cover property (@(posedge ref_clk) disable iff (!rst_n) isSys);
  c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) isWake ##1 pcLoad);
  c_badAddr: cover property (@(posedge ref_clk) disable iff (!rst_n) pslverr);
endmodule : rsi_reset_state_init

// *** design/rsi_pkg.sv ***
// Package for the reset-state register bank: offsets, masks, reset values, types.
// Assumes a 32-bit APB slave and 8-bit peripheral registers in the low byte.
package rsi_pkg;

  localparam int RSI_PORTS = 9;
  localparam int RSI_MISC = 13;
  localparam int RSI_PORT_A = 0;
  localparam int RSI_PORT_G = 6;
  localparam int RSI_PC_W = 21;
  localparam int RSI_STACK_DEPTH = 31;
  localparam int RSI_SP_W = 5;
  localparam int RSI_ADDR_W = 12;

  // Byte offsets; each bank is one word per port or register
  localparam logic [11:0] RSI_OFF_DIR = 12'h000;
  localparam logic [11:0] RSI_OFF_LAT = 12'h040;
  localparam logic [11:0] RSI_OFF_PIN = 12'h080;
  localparam logic [11:0] RSI_OFF_MISC = 12'h0c0;
  localparam logic [11:0] RSI_OFF_PC = 12'h100;
  localparam logic [11:0] RSI_OFF_SP = 12'h104;
  localparam logic [11:0] RSI_OFF_STKTOP = 12'h108;
  localparam logic [11:0] RSI_OFF_FLAGS = 12'h10c;
  localparam logic [11:0] RSI_OFF_GIE = 12'h110;

  // Ports in order A, B, C, D, E, F, G, H, J
  localparam logic [8:0][7:0] RSI_DIR_MASK =
    {8'hff, 8'hff, 8'hff, 8'hfe, 8'hfb, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [8:0][7:0] RSI_DIR_RST =
    {8'hff, 8'hff, 8'h1f, 8'hfe, 8'hfb, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [8:0][7:0] RSI_LAT_MASK =
    {8'hff, 8'hff, 8'hdf, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [8:0][7:0] RSI_LAT_CLR =
    {8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [8:0][7:0] RSI_PIN_MASK =
    {8'hff, 8'hff, 8'h1f, 8'hfe, 8'hfb, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] RSI_OSC_BITS = 8'hc0;

  // Misc order: baud ctl1, div high1, div2, ccp ctl 1/2, ccp values 1H 1L 2H 2L,
  // uart2 rx data, tx data, tx status, rx status
  localparam logic [12:0][7:0] RSI_MISC_MASK = {8'hff, 8'hf7, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hfb};
  localparam logic [12:0][7:0] RSI_MISC_LOAD = {8'hfe, 8'hf7, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hfb};
  localparam logic [12:0][7:0] RSI_MISC_RST = {8'h00, 8'h02, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};

  localparam logic [20:0] RSI_VEC_RESET = 21'h000000;
  localparam logic [20:0] RSI_VEC_HIGH = 21'h000008;
  localparam logic [20:0] RSI_VEC_LOW = 21'h000018;

  typedef enum logic [1:0] {
    RSI_CLS_NONE = 2'b00,
    RSI_CLS_POR = 2'b01,
    RSI_CLS_SYS = 2'b11,
    RSI_CLS_WAKE = 2'b10
  } rsi_class_t;

  typedef struct packed {
    logic por;
    logic sys;
    logic wake;
    logic byIrq;
    logic highPri;
  } rsi_event_t;

endpackage : rsi_pkg

// *** design/rsi_port_reg.sv ***
// One I/O port: direction and latch storage plus pin synchroniser.
// Assumes reset-class strobes come from the same clock; pins are asynchronous.
`timescale 1ns/1ps
module rsi_port_reg import rsi_pkg::*; #(
  parameter logic [7:0] DIR_MASK = 8'hff,
  parameter logic [7:0] DIR_RST = 8'hff,
  parameter logic [7:0] LAT_MASK = 8'hff,
  parameter logic [7:0] LAT_CLR = 8'h00,
  parameter logic [7:0] PIN_MASK = 8'hff
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic anyReset,
  input wire logic [7:0] bitEnable,
  input wire logic wrDir,
  input wire logic wrLat,
  input wire logic [7:0] wdata,
  input wire logic [7:0] pins,
  output logic [7:0] dir,
  output logic [7:0] lat,
  output logic [7:0] pinRead
);
  logic [7:0] sync1, sync2, sync3, pinVal;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir <= 8'h00;
      lat <= 8'h00;
    end else if (anyReset) begin
      dir <= DIR_RST;
      lat <= lat & LAT_MASK & ~LAT_CLR;
    end else begin
      if (wrDir) dir <= wdata & DIR_MASK;
      if (wrLat) lat <= wdata & LAT_MASK;
    end
  end

  // Three stages; a change counts once the last two agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      pinVal <= 8'h00;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      pinVal <= (sync2 & ~(sync2 ^ sync3)) | (pinVal & (sync2 ^ sync3));
    end
  end

  assign pinRead = pinVal & PIN_MASK & bitEnable;

  property p_dirReset;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> dir == DIR_RST;
  endproperty
  a_dirReset: assert property (p_dirReset) else $error("dir not reset");

  property p_dirHold;
    @(posedge ref_clk) disable iff (!rst_n) !anyReset && !wrDir |=> $stable(dir);
  endproperty
  a_dirHold: assert property (p_dirHold) else $error("dir moved");

  property p_latClr;
    @(posedge ref_clk) disable iff (!rst_n) anyReset |=> (lat & ~(LAT_MASK & ~LAT_CLR)) == 8'h00;
  endproperty
  a_latClr: assert property (p_latClr) else $error("latch not cleared");

  property p_unimpl;
    @(posedge ref_clk) disable iff (!rst_n) (dir & ~DIR_MASK) == 8'h00 && (pinRead & ~PIN_MASK) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
endmodule : rsi_port_reg

// *** design/rsi_wake_seq.sv ***
// Wake-up sequencing: cause flags, vector load and program-counter stack push.
// Assumes the core supplies its current program counter each cycle.
`timescale 1ns/1ps
module rsi_wake_seq import rsi_pkg::*; #(
  parameter int DEPTH = RSI_STACK_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic anyReset,
  input wire rsi_event_t ev,
  input wire logic [1:0] gie,
  input wire logic [20:0] corePc,
  input wire logic [7:0] cause,
  input wire logic [7:0] flagClr,
  output logic pcLoad,
  output logic [20:0] pcValue,
  output logic [4:0] stackPtr,
  output logic [20:0] stackTop,
  output logic [7:0] irqFlags
);
  logic [20:0] stack [DEPTH];
  wire logic wakeEv = ev.wake && !anyReset;
  wire logic vectorWake = wakeEv && ev.byIrq && (gie != 2'b00);
  wire logic canPush = stackPtr < 5'(DEPTH);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcLoad <= 1'b0;
      pcValue <= RSI_VEC_RESET;
      stackPtr <= 5'h00;
    end else if (anyReset) begin
      pcLoad <= 1'b1;
      pcValue <= RSI_VEC_RESET;
      stackPtr <= 5'h00;
    end else begin
      pcLoad <= vectorWake;
      if (vectorWake) begin
        pcValue <= ev.highPri ? RSI_VEC_HIGH : RSI_VEC_LOW;
        if (canPush) stackPtr <= stackPtr + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (vectorWake && canPush && !anyReset) stack[stackPtr] <= corePc;
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) irqFlags <= 8'h00;
    else if (anyReset) irqFlags <= 8'h00;
    else irqFlags <= (irqFlags & ~flagClr) | (wakeEv ? cause : 8'h00);
  end

  assign stackTop = (stackPtr == 5'h00) ? 21'h000000 : stack[stackPtr - 5'h01];

  property p_vector;
    @(posedge ref_clk) disable iff (!rst_n) vectorWake |=>
      pcLoad && pcValue == ($past(ev.highPri) ? RSI_VEC_HIGH : RSI_VEC_LOW);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_push;
    @(posedge ref_clk) disable iff (!rst_n) vectorWake && canPush |=>
      stackPtr == $past(stackPtr) + 5'h01 ##0 stackTop == $past(corePc);
  endproperty
  a_push: assert property (p_push) else $error("stack push missing");

  property p_cause;
    @(posedge ref_clk) disable iff (!rst_n) wakeEv |=> (irqFlags & $past(cause)) == $past(cause);
  endproperty
  a_cause: assert property (p_cause) else $error("wake cause not flagged");

  c_vectorWake: cover property (@(posedge ref_clk) disable iff (!rst_n) vectorWake);
endmodule : rsi_wake_seq

// *** verif/tb_top.sv ***
// Self-checking bench for the reset-state register bank, driven over APB.
// Assumes the design package rsi_pkg and the top module rsi_reset_state_init.
`timescale 1ns/1ps
module tb_top import rsi_pkg::*;;
  logic ref_clk, rst_n, psel, penable, pwrite, oscFreesPins, pready, pslverr, pcLoad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  rsi_event_t resetEvent, ev0;
  logic [20:0] corePc, pcValue;
  logic [7:0] wakeCause, irqFlags;
  logic [8:0][7:0] portPins, portDirection, portLatch;
  logic [12:0][7:0] periphRegs;
  rsi_class_t resetClass;
  logic [4:0] stackPointer;
  logic [1:0] globalIrqEnable;
  logic errv;
  int bad_count, samples_checked;
  int cycles = 0;
  logic [7:0] expDir [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfb, 8'hfe, 8'h1f, 8'hff, 8'hff};

  rsi_reset_state_init dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetEvent(resetEvent),
    .oscFreesPins(oscFreesPins), .corePc(corePc), .wakeCause(wakeCause),
    .portPins(portPins), .portDirection(portDirection), .portLatch(portLatch),
    .periphRegs(periphRegs), .resetClass(resetClass), .pcLoad(pcLoad),
    .pcValue(pcValue), .stackPointer(stackPointer), .irqFlags(irqFlags),
    .globalIrqEnable(globalIrqEnable));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Generous ceiling; the whole sequence needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rdv, {24'h0, exp});
  endtask : rd

  task automatic pulse(input rsi_event_t e);
    @(posedge ref_clk);
    resetEvent <= e;
    @(posedge ref_clk);
    resetEvent <= '0;
    #1;
  endtask : pulse

  initial begin
    ev0 = '0;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    resetEvent = '0;
    oscFreesPins = 1'b1;
    corePc = 21'h000000;
    wakeCause = 8'h00;
    portPins = {9{8'hff}};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    ev0.por = 1'b1;
    pulse(ev0);
    check("class", 32'(resetClass), 32'h1);
    check("dirGOut", 32'(portDirection[6]), 32'h1f);
    check("txOut", 32'(periphRegs[11]), 32'h02);
    for (int i = 0; i < 9; i++) begin
      rd(12'(4 * i), expDir[i], "dir");
    end
    rd(12'h0c0, 8'h40, "baud");
    rd(12'h0ec, 8'h02, "txstat");
    apb(1'b0, 12'h0f0, 32'h0);
    check("rxstat", rdv & 32'hfffffffe, 32'h0);
    rd(12'h0c4, 8'h00, "divh");
    rd(12'h0c8, 8'h00, "div2");
    rd(12'h0e4, 8'h00, "rxdata");
    rd(12'h0e8, 8'h00, "txdata");
    rd(12'h0cc, 8'h00, "ccpctl1");
    rd(12'h0d0, 8'h00, "ccpctl2");
    for (int i = 0; i < 9; i++) begin
      rd(12'(12'h080 + 4 * i), expDir[i], "pin");
    end
    oscFreesPins <= 1'b0;
    rd(12'h080, 8'h3f, "pinA");
    rd(12'h000, 8'h3f, "dirA");
    oscFreesPins <= 1'b1;
    apb(1'b1, 12'h058, 32'hff);
    rd(12'h058, 8'hdf, "port_g_output_latch");
    apb(1'b1, 12'h044, 32'ha5);
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b1, 12'h0d4, 32'h5a);
    apb(1'b1, 12'h0cc, 32'hff);
    rd(12'h0cc, 8'h3f, "ccpctl1");
    apb(1'b1, 12'h0c0, 32'hff);
    rd(12'h0c0, 8'hfb, "baud");
    apb(1'b1, 12'h0ec, 32'hff);
    rd(12'h0ec, 8'hf7, "txstat");
    ev0 = '0;
    ev0.sys = 1'b1;
    pulse(ev0);
    check("class", 32'(resetClass), 32'h3);
    check("latGOut", 32'(portLatch[6]), 32'h1f);
    rd(12'h004, 8'hff, "dirB");
    rd(12'h044, 8'ha5, "latB");
    rd(12'h058, 8'h1f, "port_g_output_latch");
    rd(12'h0d4, 8'h5a, "ccpval");
    rd(12'h0cc, 8'h00, "ccpctl1");
    rd(12'h0c0, 8'h40, "baud");
    rd(12'h0ec, 8'h02, "txstat");
    // Wake with both enables clear: flags only, no vectoring
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b1, 12'h018, 32'h0e);
    wakeCause <= 8'h24;
    corePc <= 21'h012345;
    ev0 = '0;
    ev0.wake = 1'b1;
    pulse(ev0);
    check("class", 32'(resetClass), 32'h2);
    check("flagsOut", 32'(irqFlags), 32'h24);
    check("sp", 32'(stackPointer), 32'h0);
    rd(12'h004, 8'h55, "dirB");
    rd(12'h018, 8'h0e, "dirG");
    rd(12'h10c, 8'h24, "flags");
    apb(1'b1, 12'h10c, 32'h24);
    rd(12'h10c, 8'h00, "flags");
    apb(1'b1, 12'h110, 32'h1);
    rd(12'h110, 8'h01, "gie");
    check("gie", 32'(globalIrqEnable), 32'h1);
    ev0.byIrq = 1'b1;
    ev0.highPri = 1'b1;
    pulse(ev0);
    check("pcload", 32'(pcLoad), 32'h1);
    check("pc", 32'(pcValue), 32'h8);
    check("sp", 32'(stackPointer), 32'h1);
    apb(1'b0, 12'h108, 32'h0);
    check("top", rdv, 32'h00012345);
    apb(1'b1, 12'h110, 32'h2);
    corePc <= 21'h000abc;
    ev0.highPri = 1'b0;
    pulse(ev0);
    check("pc", 32'(pcValue), 32'h18);
    check("sp", 32'(stackPointer), 32'h2);
    apb(1'b0, 12'h108, 32'h0);
    check("top", rdv, 32'h00000abc);
    apb(1'b0, 12'h200, 32'h0);
    check("unmapped", {rdv[30:0], errv}, 32'h1);
    ev0 = '0;
    ev0.por = 1'b1;
    pulse(ev0);
    check("pc", 32'(pcValue), 32'h0);
    rd(12'h004, 8'hff, "dirB");
    wrap_up();
  end
endmodule : tb_top
